/* rtl/cst_cfg.svh */
// Offsets, field positions, reset values and codes of the status table
`ifndef CST_CFG_SVH
`define CST_CFG_SVH

// ==========================================
// Status table locations
`define CST_ADDR_SYS_ERR      12'h004
`define CST_ADDR_PROC_CFG     12'h7FA
`define CST_ADDR_RECFG_REQ    12'h7FF
`define CST_ADDR_PORT_CFG0    12'h9BB
`define CST_ADDR_PORT_CFG1    12'h9BC
`define CST_ADDR_PORT_CFG2    12'h9BD
`define CST_ADDR_TOP_FLAG_LO  12'h9C5
`define CST_ADDR_TOP_FLAG_HI  12'h9C6
`define CST_ADDR_SLOT_BASE    12'h100
`define CST_SLOT_FIRST_RSVD   12'h014
`define CST_SLOT_LAST_RSVD    12'h113

// ==========================================
// Field positions
`define CST_ERR_PROC_INVALID  6
`define CST_ERR_RUN_NO_IO     5
`define CST_ERR_RUN_LOW_BATT  4
`define CST_ERR_USED_MASK     8'h70
`define CST_PCFG_USED_MASK    8'h3F

// ==========================================
// Codes and reset values
`define CST_REQ_ASSERT        8'hAA
`define CST_REQ_NEGATE        8'h55
`define CST_FLAG_CTRL_CHAR    8'h84
`define CST_ZERO_POINT_SLOT   8'h00
`define CST_SLOT_SUM_EXPECT   8'h00
`define CST_PCFG_RESET        8'h00
`define CST_PORT_CFG_RESET    24'h000000
`define CST_TOP_FLAG_RESET    16'h000F

`endif

/* rtl/cst_pkg.sv */
// Types shared by the status table block
package cst_pkg;

    // ==========================================
    // Status table access command
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  data;
    } cst_tbl_req_t;

    // ==========================================
    // Processor configuration fields
    typedef struct packed {
        logic scanLossTimerEn;
        logic dataChangeEn;
        logic lowBattScanEn;
        logic clearOutputsIdle;
        logic forceEn;
        logic runProgramEn;
    } cst_proc_cfg_t;

    // ==========================================
    // One program memory word, 24 bits wide
    typedef logic [23:0] cst_mem_word_t;

    // ==========================================
    // Outgoing flag message request
    typedef struct packed {
        logic        valid;
        logic [7:0]  ctrlChar;
        logic [15:0] text;
    } cst_flag_msg_t;

endpackage : cst_pkg

/* rtl/cst_flag_edge.sv */
// Off-to-on transition detector for one monitored flag bit
`timescale 1ns/1ps

module cst_flag_edge (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Monitored bit and its event
    input  wire logic bitIn,
    output logic      edgePulse
);

    logic prevBit;
    logic next_prevBit;
    logic next_edgePulse;

    always_comb begin
        next_prevBit   = bitIn;
        next_edgePulse = bitIn & ~prevBit;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prevBit   <= 1'b0;
            edgePulse <= 1'b0;
        end else begin
            prevBit   <= next_prevBit;
            edgePulse <= next_edgePulse;
        end
    end

endmodule : cst_flag_edge

/* rtl/cst_table.sv */
// Configuration and status table with flag monitor for the logic controller
// Behaviour
// - Invalid I/O or processor configuration puts 170 into location 2047.
// - The request means an invalid configuration or a checksum fault, not which.
// - At power-up, slot entries 20 to 275 become zero-point slots.
// - Reserved slot entries are checksummed; mismatch raises the reconfiguration request.
// - System error bit 6 reads 1 while processor configuration is invalid.
// - Error bit 5: run attempted without I/O; bit 4: run with low battery.
// - Config bits 5,4,3 enable scan loss timer, data change, low-battery scan.
// - Config bit 2: outputs frozen when 0, cleared when 1, in idle modes.
// - Config bit 1 enables forcing, bit 0 enables programming in run.
// - Watch 16 flag bits, each off-to-on transition is a flag event.
// - Top flag address: low byte at 2501, high byte at 2502.
// - Port configuration comes from locations 2491 to 2493, writable by command.
// - Program memory words are 24 bits wide.
// - Flag message carries control character 132 with the 16 flag event bits as text.
`timescale 1ns/1ps
`include "cst_cfg.svh"

module cst_table
    import cst_pkg::*;
(
    // Clock and reset
    input  wire logic      clock,
    input  wire logic      rst_n,
    // Table access commands from the serial port
    input  wire cst_tbl_req_t tblReq,
    output logic [7:0]     rdData,
    output logic           rdValid,
    // Controller state
    input  wire logic      ioCfgInvalid,
    input  wire logic      procCfgInvalid,
    input  wire logic      runAttempt,
    input  wire logic      lowBattery,
    // Monitored flag block
    input  wire logic [15:0] flagBits,
    output cst_flag_msg_t  flagMsg,
    // Configuration outputs
    output cst_proc_cfg_t  procCfg,
    output logic [23:0]    commPortCfg,
    output logic [15:0]    topFlagAddr,
    output logic           reconfigPending
);

    // ==========================================
    // Storage
    logic [7:0]    recfgReq;
    logic [7:0]    sysErr;
    logic [7:0]    slotTab [256];
    logic [7:0]    scanIdx;
    logic [7:0]    scanSum;
    logic          sumFault;
    logic [15:0]   flagEvents;

    logic [7:0]    next_recfgReq;
    logic [7:0]    next_sysErr;
    cst_proc_cfg_t next_procCfg;
    logic [23:0]   next_commPortCfg;
    logic [15:0]   next_topFlagAddr;
    logic [7:0]    next_rdData;
    logic          next_rdValid;
    logic [7:0]    next_scanIdx;
    logic [7:0]    next_scanSum;
    logic          next_sumFault;
    cst_flag_msg_t next_flagMsg;

    logic          wrHit;
    logic          slotHit;
    logic [11:0]   slotOff;
    logic [7:0]    slotIdx;
    logic          negateWr;
    logic          raiseReq;

    // ==========================================
    // Address decode of the reserved slot area
    always_comb begin
        slotOff = tblReq.addr - `CST_ADDR_SLOT_BASE;
        slotHit = (tblReq.addr >= `CST_ADDR_SLOT_BASE + `CST_SLOT_FIRST_RSVD)
               && (tblReq.addr <= `CST_ADDR_SLOT_BASE + `CST_SLOT_LAST_RSVD);
        slotIdx = 8'(slotOff - `CST_SLOT_FIRST_RSVD);
        wrHit   = tblReq.wr;
    end

    // ==========================================
    // Reconfiguration request and system error
    always_comb begin
        negateWr = wrHit && (tblReq.addr == `CST_ADDR_RECFG_REQ)
                && (tblReq.data == `CST_REQ_NEGATE);
        // Any cause, a checksum fault included, gives the same code; software cannot tell which
        raiseReq = ioCfgInvalid | procCfgInvalid | sumFault;
        next_recfgReq = recfgReq;
        if (raiseReq) begin
            // Set beats a negate arriving in the same cycle
            next_recfgReq = `CST_REQ_ASSERT;
        end else if (negateWr) begin
            next_recfgReq = `CST_REQ_NEGATE;
        end
        next_sysErr = sysErr;
        if (negateWr) begin
            next_sysErr[`CST_ERR_RUN_NO_IO]    = 1'b0;
            next_sysErr[`CST_ERR_RUN_LOW_BATT] = 1'b0;
        end
        next_sysErr[`CST_ERR_PROC_INVALID] = procCfgInvalid;
        if (runAttempt && ioCfgInvalid) begin
            next_sysErr[`CST_ERR_RUN_NO_IO] = 1'b1;
        end
        if (runAttempt && lowBattery) begin
            next_sysErr[`CST_ERR_RUN_LOW_BATT] = 1'b1;
        end
        next_sysErr = next_sysErr & `CST_ERR_USED_MASK;
    end

    // ==========================================
    // Writable configuration locations
    always_comb begin
        next_procCfg     = procCfg;
        next_commPortCfg = commPortCfg;
        next_topFlagAddr = topFlagAddr;
        if (wrHit) begin
            unique case (tblReq.addr)
                `CST_ADDR_PROC_CFG: begin
                    // Bits 7 and 6 have no storage
                    next_procCfg = cst_proc_cfg_t'(tblReq.data[5:0]);
                end
                `CST_ADDR_PORT_CFG0: next_commPortCfg[7:0]   = tblReq.data;
                `CST_ADDR_PORT_CFG1: next_commPortCfg[15:8]  = tblReq.data;
                `CST_ADDR_PORT_CFG2: next_commPortCfg[23:16] = tblReq.data;
                `CST_ADDR_TOP_FLAG_LO: next_topFlagAddr[7:0]  = tblReq.data;
                `CST_ADDR_TOP_FLAG_HI: next_topFlagAddr[15:8] = tblReq.data;
                default: begin
                end
            endcase
        end
    end

    // ==========================================
    // Read port, one cycle latency, unmapped reads give zero
    always_comb begin
        next_rdValid = tblReq.rd;
        next_rdData  = 8'h00;
        if (tblReq.rd) begin
            if (slotHit) begin
                next_rdData = slotTab[slotIdx];
            end else begin
                unique case (tblReq.addr)
                    `CST_ADDR_SYS_ERR:      next_rdData = sysErr;
                    `CST_ADDR_PROC_CFG:     next_rdData = {2'h0, procCfg};
                    `CST_ADDR_RECFG_REQ:    next_rdData = recfgReq;
                    `CST_ADDR_PORT_CFG0:    next_rdData = commPortCfg[7:0];
                    `CST_ADDR_PORT_CFG1:    next_rdData = commPortCfg[15:8];
                    `CST_ADDR_PORT_CFG2:    next_rdData = commPortCfg[23:16];
                    `CST_ADDR_TOP_FLAG_LO:  next_rdData = topFlagAddr[7:0];
                    `CST_ADDR_TOP_FLAG_HI:  next_rdData = topFlagAddr[15:8];
                    default:                next_rdData = 8'h00;
                endcase
            end
        end
    end

    // ==========================================
    // Background checksum of the reserved slot entries
    // One entry per cycle keeps the adder small; a fault shows within 512 cycles
    always_comb begin
        next_scanIdx  = scanIdx + 8'h01;
        next_scanSum  = scanSum + slotTab[scanIdx];
        next_sumFault = sumFault;
        if (scanIdx == 8'hFF) begin
            next_scanSum  = 8'h00;
            next_sumFault = (8'(scanSum + slotTab[scanIdx]) != `CST_SLOT_SUM_EXPECT);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 256; i++) begin
                slotTab[i] <= `CST_ZERO_POINT_SLOT;
            end
        end else if (wrHit && slotHit) begin
            slotTab[slotIdx] <= tblReq.data;
        end
    end

    // ==========================================
    // Flag monitor
    for (genvar g = 0; g < 16; g++) begin : gFlag
        cst_flag_edge uEdge (
            .clock     (clock),
            .rst_n     (rst_n),
            .bitIn     (flagBits[g]),
            .edgePulse (flagEvents[g])
        );
    end

    always_comb begin
        next_flagMsg.valid    = |flagEvents;
        next_flagMsg.ctrlChar = `CST_FLAG_CTRL_CHAR;
        next_flagMsg.text     = flagEvents;
    end

    // ==========================================
    // State registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            recfgReq        <= `CST_REQ_ASSERT;
            sysErr          <= 8'h00;
            procCfg         <= cst_proc_cfg_t'(6'(`CST_PCFG_RESET));
            commPortCfg     <= `CST_PORT_CFG_RESET;
            topFlagAddr     <= `CST_TOP_FLAG_RESET;
            rdData          <= 8'h00;
            rdValid         <= 1'b0;
            scanIdx         <= 8'h00;
            scanSum         <= 8'h00;
            sumFault        <= 1'b0;
            flagMsg         <= '0;
            reconfigPending <= 1'b1;
        end else begin
            recfgReq        <= next_recfgReq;
            sysErr          <= next_sysErr;
            procCfg         <= next_procCfg;
            commPortCfg     <= next_commPortCfg;
            topFlagAddr     <= next_topFlagAddr;
            rdData          <= next_rdData;
            rdValid         <= next_rdValid;
            scanIdx         <= next_scanIdx;
            scanSum         <= next_scanSum;
            sumFault        <= next_sumFault;
            flagMsg         <= next_flagMsg;
            reconfigPending <= (next_recfgReq == `CST_REQ_ASSERT);
        end
    end

endmodule : cst_table

/* verif/cst_table_props.sv */
// Port checker for the status table
`timescale 1ns/1ps
`include "cst_cfg.svh"

module cst_table_props
    import cst_pkg::*;
(
    // Clock and reset
    input wire logic          clock,
    input wire logic          rst_n,
    // Table access
    input wire cst_tbl_req_t  tblReq,
    input wire logic [7:0]    rdData,
    input wire logic          rdValid,
    // Controller state
    input wire logic          ioCfgInvalid,
    input wire logic          procCfgInvalid,
    input wire logic          runAttempt,
    input wire logic          lowBattery,
    // Flags and configuration
    input wire logic [15:0]   flagBits,
    input wire cst_flag_msg_t flagMsg,
    input wire cst_proc_cfg_t procCfg,
    input wire logic [23:0]   commPortCfg,
    input wire logic [15:0]   topFlagAddr,
    input wire logic          reconfigPending
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Decode
    logic wrCfg;
    logic rdCfg;
    assign wrCfg = tblReq.wr && tblReq.addr == `CST_ADDR_PROC_CFG;
    assign rdCfg = tblReq.rd && tblReq.addr == `CST_ADDR_PROC_CFG;
    // Reset-time history is excluded, the edge detector restarts from zero
    sequence flagRise_s;
        $past(rst_n) && (flagBits & ~$past(flagBits)) != 16'h0000;
    endsequence
    sequence flagMsg_s;
        ##2 flagMsg.valid && flagMsg.text == ($past(flagBits, 2) & ~$past(flagBits, 3));
    endsequence
    // ==========================================
    // Properties
    chk_rd_answer: assert property (tblReq.rd |=> rdValid)
        else $error("read not answered");
    chk_rd_idle: assert property (!tblReq.rd |=> !rdValid && rdData == 8'h00)
        else $error("read answer without read");
    chk_req_raise: assert property (ioCfgInvalid || procCfgInvalid |=> reconfigPending)
        else $error("request not raised");
    chk_req_hold: assert property (tblReq.wr && tblReq.addr == `CST_ADDR_RECFG_REQ
        && tblReq.data != `CST_REQ_NEGATE && reconfigPending |=> reconfigPending)
        else $error("request cleared by wrong value");
    chk_cfg_write: assert property (wrCfg |=> procCfg == $past(tblReq.data[5:0]))
        else $error("config write lost");
    chk_cfg_read: assert property (rdCfg |=> rdData == {2'h0, $past(procCfg)})
        else $error("config read wrong");
    chk_err_read: assert property ($past(rst_n) && tblReq.rd && tblReq.addr == `CST_ADDR_SYS_ERR
        |=> rdData[7] == 1'b0 && rdData[3:0] == 4'h0
        && rdData[6] == $past(procCfgInvalid, 2))
        else $error("error byte wrong");
    chk_top_low: assert property (tblReq.wr && tblReq.addr == `CST_ADDR_TOP_FLAG_LO
        |=> topFlagAddr[7:0] == $past(tblReq.data))
        else $error("top flag low byte lost");
    chk_port_low: assert property (tblReq.wr && tblReq.addr == `CST_ADDR_PORT_CFG0
        |=> commPortCfg[7:0] == $past(tblReq.data))
        else $error("port config byte lost");
    chk_flag_event: assert property (flagRise_s |-> flagMsg_s)
        else $error("flag event missing");
    chk_flag_char: assert property (flagMsg.valid |-> flagMsg.ctrlChar == `CST_FLAG_CTRL_CHAR)
        else $error("flag control character wrong");
endmodule : cst_table_props

bind cst_table cst_table_props u_props (.clock(clock), .rst_n(rst_n), .tblReq(tblReq),
    .rdData(rdData), .rdValid(rdValid), .ioCfgInvalid(ioCfgInvalid),
    .procCfgInvalid(procCfgInvalid), .runAttempt(runAttempt), .lowBattery(lowBattery),
    .flagBits(flagBits), .flagMsg(flagMsg), .procCfg(procCfg), .commPortCfg(commPortCfg),
    .topFlagAddr(topFlagAddr), .reconfigPending(reconfigPending));

/* verif/cst_host_model.sv */
// Host side model issuing status table commands
`timescale 1ns/1ps
`include "cst_cfg.svh"

module cst_host_model
    import cst_pkg::*;
(
    // Clock
    input wire logic     clock,
    // Command to the table
    output cst_tbl_req_t tblReq
);
    initial tblReq = '0;
    // Idle lines show the inverse so a stale value is never mistaken for data
    task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(negedge clock);
        tblReq <= '{wr: w, rd: ~w, addr: a, data: d};
        @(negedge clock);
        tblReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask : access
    // Corrupted replies never reach this model; a retry is just a new access
    // Also called while a configuration is still invalid, where the request must hold
    task automatic negate();
        access(1'b1, `CST_ADDR_RECFG_REQ, `CST_REQ_NEGATE);
    endtask : negate
endmodule : cst_host_model

/* verif/tb_cst_table.sv */
// Self-checking bench for the status table
`timescale 1ns/1ps
`include "cst_cfg.svh"

module tb_cst_table
    import cst_pkg::*;
;
    logic          clock = 1'b0;
    logic          rst_n = 1'b0;
    cst_tbl_req_t  tblReq;
    logic [7:0]    rdData;
    logic          rdValid;
    logic          ioCfgInvalid = 1'b0;
    logic          procCfgInvalid = 1'b0;
    logic          runAttempt = 1'b0;
    logic          lowBattery = 1'b0;
    logic [15:0]   flagBits = 16'h0000;
    cst_flag_msg_t flagMsg;
    cst_proc_cfg_t procCfg;
    logic [23:0]   commPortCfg;
    logic [15:0]   topFlagAddr;
    logic          reconfigPending;
    int            nMismatch = 0;
    int            totalChecks = 0;
    integer        seed = 32'h1072;
    logic [7:0]    rq[$];
    logic [15:0]   fq[$];
    logic [7:0]    d;
    logic [15:0]   r;

    always #2 clock = ~clock;

    cst_table uut (.clock(clock), .rst_n(rst_n), .tblReq(tblReq), .rdData(rdData),
        .rdValid(rdValid), .ioCfgInvalid(ioCfgInvalid), .procCfgInvalid(procCfgInvalid),
        .runAttempt(runAttempt), .lowBattery(lowBattery), .flagBits(flagBits),
        .flagMsg(flagMsg), .procCfg(procCfg), .commPortCfg(commPortCfg),
        .topFlagAddr(topFlagAddr), .reconfigPending(reconfigPending));
    cst_host_model host (.clock(clock), .tblReq(tblReq));

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        rq.push_back(e);
        host.access(1'b0, a, 8'h00);
    endtask : rd
    task automatic endTest(input string name);
        $display("test %s finished", name);
    endtask : endTest
    task automatic giveVerdict();
        $display("checks=%0d mismatches=%0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : giveVerdict

    // ==========================================
    // Result monitors, oldest note first
    always @(negedge clock) begin
        if (rdValid === 1'b1) begin
            if (rq.size() > 0) check(rdData, rq.pop_front());
            else check(24'h1, 24'h0);
        end
        if (flagMsg.valid === 1'b1) begin
            if (fq.size() > 0) check(flagMsg.text, fq.pop_front());
            else check(24'h2, 24'h0);
            check(flagMsg.ctrlChar, `CST_FLAG_CTRL_CHAR);
        end
    end
    initial begin
        repeat (20000) @(posedge clock);
        nMismatch++;
        giveVerdict();
    end

    // ==========================================
    // Scenarios
    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        check(reconfigPending, 1'b1);
        check(topFlagAddr, `CST_TOP_FLAG_RESET);
        check(commPortCfg, `CST_PORT_CFG_RESET);
        check($bits(cst_mem_word_t), 24'h18);
        rd(`CST_ADDR_RECFG_REQ, `CST_REQ_ASSERT);
        rd(12'h114, `CST_ZERO_POINT_SLOT);
        rd(12'h213, `CST_ZERO_POINT_SLOT);
        rd(12'h005, 8'h00);
        endTest("reset");
        for (int i = 0; i < 10; i++) begin
            d = (i < 6) ? (8'h01 << i) : $random(seed);
            host.access(1'b1, `CST_ADDR_PROC_CFG, d);
            check(procCfg, d[5:0]);
            rd(`CST_ADDR_PROC_CFG, {2'h0, d[5:0]});
        end
        host.access(1'b1, `CST_ADDR_SYS_ERR, 8'hFF);
        rd(`CST_ADDR_SYS_ERR, 8'h00);
        for (int j = 0; j < 3; j++) begin
            d = $random(seed);
            host.access(1'b1, 12'(`CST_ADDR_PORT_CFG0 + j), d);
            check(commPortCfg[8*j +: 8], d);
            rd(12'(`CST_ADDR_PORT_CFG0 + j), d);
        end
        r = 16'h000F + (16'($random(seed)) % 16'h0FF1);
        host.access(1'b1, `CST_ADDR_TOP_FLAG_LO, r[7:0]);
        host.access(1'b1, `CST_ADDR_TOP_FLAG_HI, r[15:8]);
        check(topFlagAddr, r);
        rd(`CST_ADDR_TOP_FLAG_HI, r[15:8]);
        endTest("config");
        host.access(1'b1, `CST_ADDR_RECFG_REQ, 8'h12);
        check(reconfigPending, 1'b1);
        host.negate();
        @(negedge clock);
        check(reconfigPending, 1'b0);
        rd(`CST_ADDR_RECFG_REQ, `CST_REQ_NEGATE);
        // A stray value must not overwrite a negated request
        host.access(1'b1, `CST_ADDR_RECFG_REQ, 8'h12);
        rd(`CST_ADDR_RECFG_REQ, `CST_REQ_NEGATE);
        ioCfgInvalid = 1'b1;
        runAttempt = 1'b1;
        lowBattery = 1'b1;
        @(negedge clock);
        runAttempt = 1'b0;
        lowBattery = 1'b0;
        @(negedge clock);
        check(reconfigPending, 1'b1);
        rd(`CST_ADDR_SYS_ERR, 8'h30);
        rd(`CST_ADDR_RECFG_REQ, `CST_REQ_ASSERT);
        host.negate();
        @(negedge clock);
        check(reconfigPending, 1'b1);
        ioCfgInvalid = 1'b0;
        host.negate();
        rd(`CST_ADDR_SYS_ERR, 8'h00);
        procCfgInvalid = 1'b1;
        repeat (2) @(negedge clock);
        check(reconfigPending, 1'b1);
        rd(`CST_ADDR_SYS_ERR, 8'h40);
        procCfgInvalid = 1'b0;
        host.negate();
        endTest("request");
        // Corrupt one reserved slot, then repair it; a pass takes 256 cycles
        host.access(1'b1, 12'h150, 8'h01);
        repeat (520) @(negedge clock);
        check(reconfigPending, 1'b1);
        host.access(1'b1, 12'h150, 8'h00);
        repeat (520) @(negedge clock);
        host.negate();
        @(negedge clock);
        check(reconfigPending, 1'b0);
        endTest("checksum");
        // Mid-run reset must restore the power-up defaults over dirty state
        host.access(1'b1, 12'h150, 8'h01);
        host.access(1'b1, `CST_ADDR_TOP_FLAG_HI, 8'h0A);
        @(negedge clock) rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        check(reconfigPending, 1'b1);
        check(topFlagAddr, `CST_TOP_FLAG_RESET);
        check(procCfg, `CST_PCFG_RESET);
        rd(12'h150, `CST_ZERO_POINT_SLOT);
        rd(`CST_ADDR_SYS_ERR, 8'h00);
        host.negate();
        check(reconfigPending, 1'b0);
        endTest("midreset");
        for (int k = 0; k < 40; k++) begin
            @(negedge clock);
            r = $random(seed);
            if ((r & ~flagBits) != 16'h0000) fq.push_back(r & ~flagBits);
            flagBits = r;
        end
        @(negedge clock) flagBits = 16'h0000;
        repeat (5) @(negedge clock);
        check(fq.size() + rq.size(), 24'h0);
        endTest("flags");
        giveVerdict();
    end
endmodule : tb_cst_table
